// ### design/wsf_framer.sv
/*
  wsf_framer: wan sublayer datapath, tx mapper/framer and rx deframer, plus
  its tx buffer fifo. assumes the pma receive words arrive already on
  i_sys_clk, qualified by a valid strobe at the word rate, and that the
  management logic drives the mode and framing inputs on the same clock.
*/
// Functional notes
// - wide area select bit enters wan operation
// - status output shows wan operation active
// - one control drives both directions together
// - tx pcs words mapped into payload envelope
// - tx inserts section, line, path overhead
// - tx scrambles frame, then sends to pma
// - rx finds octet and frame boundaries
// - rx descrambles, checks parity and alarms
// - rx reads pointer to locate envelope
// - rx extracts payload to the pcs
// - framing octets are f6 then 28
// - all framing octets from two fields
// - wan stream carries framed 32-bit payload words
`default_nettype none

// small synchronous fifo; in_ready low when full stalls the writer
module wsf_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rstn,
  // write side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // read side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];    // storage
  logic [AW-1:0]    wr_q;             // write pointer
  logic [AW-1:0]    rd_q;             // read pointer
  logic [AW:0]      cnt_q;            // fill level
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // storage needs no reset, it is only read behind the fill level
  always_ff @(posedge i_sys_clk)
  begin
    if (push)
      mem_q[wr_q] <= i_in_data;
  end

  // pointers and fill level
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module wsf_framer #(
  parameter int unsigned ROW_WORDS = 4320          // words per row
) (
  // clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_rstn,
  // management control and status
  input  wire logic                i_wide_area_select,
  input  wire logic [7:0]          i_tx_first_framing_value,
  input  wire logic [7:0]          i_tx_second_framing_value,
  output logic                     o_wan_active,
  // pcs side
  input  wire wsf_pkg::wsf_word_t  i_pcs_tx,
  output logic                     o_pcs_tx_ready,
  output wsf_pkg::wsf_word_t       o_pcs_rx,
  // pma side
  output wsf_pkg::wsf_word_t       o_pma_tx,
  input  wire wsf_pkg::wsf_word_t  i_pma_rx,
  // receive alarms
  output logic                     o_rx_lof,
  output logic                     o_rx_b1_err,
  output logic                     o_rx_ptr_err
);
  import wsf_pkg::*;

  localparam int unsigned CW = $clog2(ROW_WORDS);

  // frame-synchronous x^7+x^6+1 scrambler over one word, msb first;
  // returns next state above the scrambled word
  function automatic logic [38:0] scr_word(input logic [6:0] st,
                                           input logic [31:0] w);
    logic [6:0]  s;
    logic [31:0] o;
    s = st;
    o = '0;
    for (int i = 31; i >= 0; i--)
    begin
      o[i] = w[i] ^ s[6];
      s    = {s[5:0], s[6] ^ s[5]};
    end
    return {s, o};
  endfunction

  // xor of the four bytes of a word, one bip-8 step
  function automatic logic [7:0] bip_word(input logic [31:0] w);
    return w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0];
  endfunction

  // mode register: one bit steers both directions
  logic wan_q;
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      wan_q <= 1'b0;
    else
      wan_q <= i_wide_area_select;
  end
  assign o_wan_active = wan_q;

  // transmit buffer between pcs and the mapper
  logic        fifo_valid;
  logic [31:0] fifo_data;
  logic        fifo_pop;
  wsf_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (i_pcs_tx.valid),
    .i_in_data   (i_pcs_tx.data),
    .o_in_ready  (o_pcs_tx_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (fifo_pop)
  );

  // transmit frame position and running state
  logic [3:0]    tx_row_q;
  logic [CW-1:0] tx_col_q;
  logic [6:0]    tx_scr_q;
  logic [7:0]    tx_bip_q;            // parity of frame in progress
  logic [7:0]    tx_b1_q;             // parity of previous frame
  logic [31:0]   tx_word;             // word before scrambling
  logic          tx_unscr;
  logic          tx_payload;
  logic [38:0]   tx_scr;
  logic [31:0]   tx_line;
  logic          tx_fstart;

  assign tx_fstart  = (tx_row_q == '0) && (tx_col_q == '0);
  assign tx_unscr   = (tx_row_q == '0) && (tx_col_q < CW'(UNSCR_WORDS));
  assign tx_payload = (tx_col_q > CW'(TOH_WORDS) + CW'(TX_PTR));
  // in wan mode payload words leave the fifo only in envelope data columns, so the
  // fifo fills during overhead and back-pressures the pcs
  assign fifo_pop   = wan_q ? tx_payload : 1'b1;

  // overhead and payload selection for the current column
  always_comb
  begin
    tx_word = '0;
    if (tx_row_q == '0 && tx_col_q < CW'(FRM_OCT_WORDS))
      tx_word = {4{i_tx_first_framing_value}};
    else if (tx_row_q == '0 && tx_col_q < CW'(2*FRM_OCT_WORDS))
      tx_word = {4{i_tx_second_framing_value}};
    else if (tx_row_q == 4'(B1_ROW) && tx_col_q == '0)
      tx_word = {tx_b1_q, 24'h0};
    else if (tx_row_q == 4'(PTR_ROW) && tx_col_q == '0)
      tx_word = {PTR_FLAGS, TX_PTR, 16'h0};
    else if (tx_col_q == CW'(TOH_WORDS) + CW'(TX_PTR))
      tx_word = {16'h0, PATH_LABEL, 8'h0};
    else if (tx_payload && fifo_valid)
      tx_word = fifo_data;
  end

  // the scrambler is preset at the first scrambled word of each frame
  assign tx_scr  = scr_word(tx_col_q == CW'(UNSCR_WORDS) && tx_row_q == '0
                            ? SCR_SEED : tx_scr_q, tx_word);
  assign tx_line = tx_unscr ? tx_word : tx_scr[31:0];

  // transmit framer state; held at frame start while bypassed
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tx_row_q <= '0;
      tx_col_q <= '0;
      tx_scr_q <= SCR_SEED;
      tx_bip_q <= '0;
      tx_b1_q  <= '0;
    end
    else if (!wan_q)
    begin
      tx_row_q <= '0;
      tx_col_q <= '0;
      tx_scr_q <= SCR_SEED;
      tx_bip_q <= '0;
      tx_b1_q  <= '0;
    end
    else
    begin
      tx_scr_q <= tx_scr[38:32];
      // parity covers the scrambled line words of one whole frame
      tx_bip_q <= (tx_fstart ? 8'h0 : tx_bip_q) ^ bip_word(tx_line);
      if (tx_fstart)
        tx_b1_q <= tx_bip_q;
      if (tx_col_q == CW'(ROW_WORDS - 1))
      begin
        tx_col_q <= '0;
        tx_row_q <= (tx_row_q == 4'(ROWS - 1)) ? '0 : tx_row_q + 1'b1;
      end
      else
        tx_col_q <= tx_col_q + 1'b1;
    end
  end

  // registered pma output, framed or passed through
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_pma_tx <= '0;
    else if (wan_q)
      o_pma_tx <= '{valid: 1'b1, data: tx_line};
    else
      o_pma_tx <= '{valid: fifo_valid, data: fifo_data};
  end

  // receive window: two held words and the arriving one
  logic [31:0]   rx_w1_q;
  logic [31:0]   rx_w2_q;
  logic [95:0]   rx_win;
  logic [31:0]   rx_match;
  logic [4:0]    rx_off_q;            // locked bit offset
  logic [4:0]    rx_first;
  wsf_state_t    rx_st_q;
  logic [3:0]    rx_row_q;
  logic [CW-1:0] rx_col_q;
  logic [6:0]    rx_scr_q;
  logic [7:0]    rx_bip_q;
  logic [7:0]    rx_b1_q;
  logic          rx_b1_ok_q;          // a whole frame has been summed
  logic [9:0]    rx_ptr_q;
  logic [31:0]   rx_al;
  logic [38:0]   rx_dscr;
  logic [31:0]   rx_word;
  logic          rx_fstart;
  logic          rx_chk;

  assign rx_win = {rx_w2_q, rx_w1_q, i_pma_rx.data};
  // boundary marker: last four first octets then four second octets
  for (genvar k = 0; k < 32; k++)
  begin : g_search
    assign rx_match[k] = (rx_win[k +: 64] ==
                          {{4{FIRST_OCT_RST}}, {4{SECOND_OCT_RST}}});
  end

  // lowest offset that shows the marker
  always_comb
  begin
    rx_first = '0;
    for (int i = 31; i >= 0; i--)
    begin
      if (rx_match[i])
        rx_first = 5'(i);
    end
  end

  assign rx_al     = rx_win[rx_off_q +: 32];
  assign rx_fstart = (rx_row_q == '0) && (rx_col_q == '0);
  // marker check lands on the first second-octet word of row zero
  assign rx_chk    = (rx_row_q == '0) && (rx_col_q == CW'(FRM_OCT_WORDS));
  assign rx_dscr   = scr_word(rx_col_q == CW'(UNSCR_WORDS) && rx_row_q == '0
                              ? SCR_SEED : rx_scr_q, rx_al);
  assign rx_word   = (rx_row_q == '0 && rx_col_q < CW'(UNSCR_WORDS))
                     ? rx_al : rx_dscr[31:0];

  // receive frame search, position, descrambler and overhead checks
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rx_w1_q <= '0;
      rx_w2_q <= '0;
      rx_off_q <= '0;
      rx_st_q <= ST_HUNT;
      rx_row_q <= '0;
      rx_col_q <= '0;
      rx_scr_q <= SCR_SEED;
      rx_bip_q <= '0;
      rx_b1_q <= '0;
      rx_b1_ok_q <= 1'b0;
      rx_ptr_q <= '0;
      o_rx_b1_err <= 1'b0;
      o_rx_ptr_err <= 1'b0;
    end
    else if (!wan_q)
    begin
      rx_st_q <= ST_HUNT;
      rx_b1_ok_q <= 1'b0;
      o_rx_b1_err <= 1'b0;
      o_rx_ptr_err <= 1'b0;
    end
    else
    begin
      o_rx_b1_err <= 1'b0;
      if (i_pma_rx.valid)
      begin
        rx_w2_q <= rx_w1_q;
        rx_w1_q <= i_pma_rx.data;
        rx_scr_q <= rx_dscr[38:32];
        rx_col_q <= (rx_col_q == CW'(ROW_WORDS - 1)) ? '0 : rx_col_q + 1'b1;
        if (rx_col_q == CW'(ROW_WORDS - 1))
          rx_row_q <= (rx_row_q == 4'(ROWS - 1)) ? '0 : rx_row_q + 1'b1;
        rx_bip_q <= (rx_fstart ? 8'h0 : rx_bip_q) ^ bip_word(rx_al);
        if (rx_fstart)
        begin
          rx_b1_q <= rx_bip_q;
          rx_b1_ok_q <= (rx_st_q == ST_SYNC);
        end
        // parity is judged only while locked, a lost frame has no meaning
        if (rx_row_q == 4'(B1_ROW) && rx_col_q == '0 && rx_b1_ok_q &&
            rx_st_q == ST_SYNC)
          o_rx_b1_err <= (rx_word[31:24] != rx_b1_q);
        if (rx_row_q == 4'(PTR_ROW) && rx_col_q == '0)
        begin
          rx_ptr_q <= rx_word[25:16];
          o_rx_ptr_err <= (rx_word[25:16] >
                           10'(ROW_WORDS - TOH_WORDS - 1));
        end
        case (rx_st_q)
          ST_HUNT:
          begin
            // lock offset, next word is the second of the second octets
            if (rx_match != '0)
            begin
              rx_off_q <= rx_first;
              rx_st_q <= ST_PRESYNC;
              rx_row_q <= '0;
              rx_col_q <= CW'(FRM_OCT_WORDS + 1);
              rx_b1_ok_q <= 1'b0;
            end
          end
          ST_PRESYNC, ST_SYNC:
          begin
            // one confirmation promotes, any miss drops back to search
            if (rx_chk)
              rx_st_q <= rx_match[rx_off_q] ? ST_SYNC : ST_HUNT;
          end
          default:
            rx_st_q <= ST_HUNT;
        endcase
      end
    end
  end

  // bypass forces loss of frame at once; the search state only drops back
  // one edge later, and lock must never be reported outside wan operation
  assign o_rx_lof = !wan_q || (rx_st_q != ST_SYNC);

  // payload extraction, skipping overhead and the path overhead column
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_pcs_rx <= '0;
    else if (!wan_q)
      o_pcs_rx <= i_pma_rx;
    else
      o_pcs_rx <= '{valid: i_pma_rx.valid && rx_st_q == ST_SYNC &&
                           rx_col_q > CW'(TOH_WORDS) + CW'(rx_ptr_q),
                    data: rx_word};
  end
endmodule
`default_nettype wire

// ### include/wsf_pkg.sv
/*
  wsf_pkg: shared constants, types and states of the wan sublayer framer.
  assumes 32-bit words on both the pcs and the pma side, one clock domain.
*/
`default_nettype none
package wsf_pkg;
  localparam int unsigned WORD_W        = 32;          // datapath width
  localparam int unsigned ROWS          = 9;           // rows per frame
  localparam int unsigned TOH_WORDS     = 144;         // transport oh cols
  localparam int unsigned FRM_OCT_WORDS = 48;          // 192 octets each
  localparam int unsigned UNSCR_WORDS   = 97;          // framing + trace
  localparam int unsigned B1_ROW        = 1;           // parity byte row
  localparam int unsigned PTR_ROW       = 3;           // pointer word row
  localparam logic [7:0]  FIRST_OCT_RST = 8'hf6;       // first framing octet
  localparam logic [7:0]  SECOND_OCT_RST = 8'h28;      // second framing octet
  localparam logic [6:0]  SCR_SEED      = 7'h7f;       // scrambler preset
  localparam logic [9:0]  TX_PTR        = 10'h000;     // envelope offset
  localparam logic [5:0]  PTR_FLAGS     = 6'h18;       // ndf off, ss bits
  localparam logic [7:0]  PATH_LABEL    = 8'h1a;       // path signal label
  localparam int unsigned FIFO_DEPTH    = 4;           // tx buffer words

  // one data word with its valid qualifier
  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] data;
  } wsf_word_t;

  // receive frame search states, one-hot
  typedef enum logic [2:0] {
    ST_HUNT    = 3'b001,
    ST_PRESYNC = 3'b010,
    ST_SYNC    = 3'b100
  } wsf_state_t;
endpackage
`default_nettype wire

// ### verification/tb_wsf_framer.sv
/*
  tb_wsf_framer: bypass and wan loopback traffic through the framer.
  assumes the pma model returns line words, so tx words come back on rx.
*/
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  error_cnt++; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_wsf_framer;
  timeunit 1ns;
  timeprecision 1ps;
  import wsf_pkg::*;
  localparam int unsigned RW    = 160;    // short rows keep frames small
  localparam int          LIMIT = 20000;  // cycle ceiling of the run
  logic        clk      = 1'b0;   // system clock
  logic        rstn     = 1'b0;   // reset, active low
  logic        sel      = 1'b0;   // wan mode request
  logic        flip     = 1'b0;   // line bit error request
  logic [3:0]  mode_hist = 4'h0;  // recent mode samples
  logic [7:0]  first_v  = 8'hf6;  // first framing field
  logic [7:0]  second_v = 8'h28;  // second framing field
  wsf_word_t   pcs_tx   = '0;     // pcs write word
  wsf_word_t   pcs_rx, pma_tx, pma_rx;
  logic        tx_ready, wan_act, lof, b1_err, ptr_err;
  logic [31:0] exp_q[$];          // words expected back at the pcs
  logic [31:0] exp_w;
  logic [31:0] rnd = 32'h1d;      // xorshift state
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          stalls = 0;        // cycles the buffer refused
  int          b1_cnt = 0;
  int          cyc = 0;
  always #5 clk = ~clk;
  wsf_framer #(.ROW_WORDS(RW)) dut_u (
    .i_sys_clk(clk), .i_rstn(rstn), .i_wide_area_select(sel),
    .i_tx_first_framing_value(first_v), .i_tx_second_framing_value(second_v),
    .o_wan_active(wan_act), .i_pcs_tx(pcs_tx), .o_pcs_tx_ready(tx_ready),
    .o_pcs_rx(pcs_rx), .o_pma_tx(pma_tx), .i_pma_rx(pma_rx),
    .o_rx_lof(lof), .o_rx_b1_err(b1_err), .o_rx_ptr_err(ptr_err));
  wsf_pma_model pma_u (
    .i_sys_clk(clk), .i_rstn(rstn), .i_line(pma_tx), .i_flip(flip),
    .o_rx(pma_rx));
  // xorshift never yields zero, so real words differ from underrun fill
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic conclude();
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hold the word until an edge with ready high takes it
  task automatic put(input logic [31:0] d);
    pcs_tx <= '{1'b1, d};
    exp_q.push_back(d);
    @(negedge clk);
    while (tx_ready !== 1'b1)
    begin
      stalls++;
      @(negedge clk);
    end
    @(posedge clk);
  endtask
  // back to back random words, entered just after a rising edge
  task automatic burst(input int n);
    repeat (n)
    begin
      rnd = xs(rnd);
      put(rnd);
    end
    pcs_tx <= '0;
  endtask
  // watcher: every nonzero word at the pcs is the oldest note
  always @(posedge clk)
  begin
    cyc++;
    if (b1_err === 1'b1)
      b1_cnt++;
    mode_hist = {mode_hist[2:0], wan_act};
    // line words in flight across a mode change are not pcs traffic
    if (pcs_rx.valid === 1'b1 && pcs_rx.data !== '0 &&
        (mode_hist == 4'h0 || mode_hist == 4'hf))
    begin
      exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 32'h0;
      `CHK(pcs_rx.data, exp_w)
    end
    if (cyc == LIMIT)
    begin
      error_cnt++;
      conclude();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    burst(8);
    repeat (10) @(negedge clk);
    `CHK(exp_q.size(), 0)
    @(posedge clk);
    first_v <= 8'hc3;
    second_v <= 8'h5a;
    sel <= 1'b1;
    repeat (100) @(negedge clk);
    `CHK(wan_act, 1'b1)
    @(posedge clk);
    sel <= 1'b0;
    repeat (10) @(negedge clk);
    `CHK(lof, 1'b1)
    @(posedge clk);
    first_v <= FIRST_OCT_RST;
    second_v <= SECOND_OCT_RST;
    sel <= 1'b1;
    for (int i = 0; i < 6000 && lof !== 1'b0; i++)
      @(negedge clk);
    `CHK(lof, 1'b0)
    @(posedge clk);
    burst(40);
    // one corrupted overhead bit, about twenty words past a row start,
    // must give exactly one parity alarm and keep the lock
    for (int i = 0; i < 400 && pcs_rx.valid !== 1'b1; i++)
      @(negedge clk);
    for (int i = 0; i < 400 && pcs_rx.valid === 1'b1; i++)
      @(negedge clk);
    repeat (20) @(posedge clk);
    flip <= 1'b1;
    @(posedge clk);
    flip <= 1'b0;
    repeat (3000) @(negedge clk);
    `CHK(exp_q.size(), 0)
    `CHK(stalls > 0, 1'b1)
    `CHK(b1_cnt, 1)
    `CHK(lof, 1'b0)
    `CHK(ptr_err, 1'b0)
    @(posedge clk);
    sel <= 1'b0;
    repeat (8) @(posedge clk);
    burst(4);
    repeat (10) @(negedge clk);
    `CHK(exp_q.size(), 0)
    conclude();
  end
endmodule
`default_nettype wire

// ### verification/wsf_framer_checker.sv
/*
  wsf_framer_checker: port assertions of the framer top.
  assumes one clock domain, bound to every wsf_framer instance.
*/
`default_nettype none
module wsf_framer_checker #(
  parameter int unsigned ROW_WORDS = 4320  // words per row
) (
  // clock and reset
  input wire logic                i_sys_clk,
  input wire logic                i_rstn,
  // mode and framing
  input wire logic                i_wide_area_select,
  input wire logic [7:0]          i_tx_first_framing_value,
  input wire logic [7:0]          i_tx_second_framing_value,
  input wire logic                o_wan_active,
  // datapath and alarms
  input wire logic                o_pcs_tx_ready,
  input wire wsf_pkg::wsf_word_t  o_pcs_rx,
  input wire wsf_pkg::wsf_word_t  o_pma_tx,
  input wire wsf_pkg::wsf_word_t  i_pma_rx,
  input wire logic                o_rx_lof,
  input wire logic                o_rx_b1_err
);
  timeunit 1ns;
  timeprecision 1ps;
  import wsf_pkg::*;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  // status is the select one edge late, skip the edge after reset
  AST_MODE: assert property ($past(i_rstn) |->
    o_wan_active == $past(i_wide_area_select))
    else $error("mode status does not follow select");
  // receive framer reports loss of frame while bypassed
  AST_LOF_OFF: assert property ((!o_wan_active)[*3] |-> o_rx_lof)
    else $error("frame lock while bypassed");
  AST_LOCK_WAN: assert property (!o_rx_lof |-> o_wan_active)
    else $error("frame lock outside wan mode");
  AST_TX_VALID: assert property (o_wan_active[*2] |-> o_pma_tx.valid)
    else $error("line word missing in wan mode");
  AST_FIRST: assert property ($rose(o_wan_active) |=>
    (o_pma_tx.data == {4{i_tx_first_framing_value}})[*8])
    else $error("first framing words wrong");
  AST_SECOND: assert property ($rose(o_wan_active) |-> ##49
    o_pma_tx.data == {4{i_tx_second_framing_value}})
    else $error("second framing word wrong");
  AST_RDY_BYP: assert property ((!o_wan_active)[*6] |-> o_pcs_tx_ready)
    else $error("tx buffer refuses in bypass");
  AST_RX_BYP: assert property ((!o_wan_active)[*3] |->
    o_pcs_rx == $past(i_pma_rx))
    else $error("rx bypass word wrong");
  AST_RX_SYNC: assert property (o_pcs_rx.valid && o_wan_active &&
    $past(o_wan_active, 2) |-> !$past(o_rx_lof))
    else $error("payload passed without lock");
  AST_B1: assert property (o_rx_b1_err |-> !$past(o_rx_lof) ##1
    !o_rx_b1_err)
    else $error("parity flag outside lock or not a pulse");
  COV_WAN: cover property ($rose(o_wan_active));
  COV_LOCK: cover property ($fell(o_rx_lof));
  COV_FULL: cover property (o_wan_active && !o_pcs_tx_ready);
  COV_B1: cover property (o_rx_b1_err);
endmodule
bind wsf_framer wsf_framer_checker #(.ROW_WORDS(ROW_WORDS)) chk_u (
  .i_sys_clk, .i_rstn, .i_wide_area_select, .i_tx_first_framing_value,
  .i_tx_second_framing_value, .o_wan_active, .o_pcs_tx_ready, .o_pcs_rx,
  .o_pma_tx, .i_pma_rx, .o_rx_lof, .o_rx_b1_err);
`default_nettype wire

// ### verification/wsf_pma_model.sv
/*
  wsf_pma_model: line side loopback, returns each tx line word as rx word.
  assumes it shares the framer clock and reset.
*/
`default_nettype none
module wsf_pma_model (
  // clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_rstn,
  // line words in, receive words out
  input  wire wsf_pkg::wsf_word_t  i_line,
  input  wire logic                i_flip,
  output var  wsf_pkg::wsf_word_t  o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  import wsf_pkg::*;
  // one 32-bit word per strobe; idle words invert so stale data never holds
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rx <= '0;
    else if (i_line.valid)
      // i_flip corrupts bit 0 of one word to provoke a parity alarm
      o_rx <= '{1'b1, i_line.data ^ {31'h0, i_flip}};
    else
      o_rx <= '{1'b0, ~o_rx.data};
  end
endmodule
`default_nettype wire
